//--- core/plhv_pkg.sv
// Function
// [R1] automatic holdover tri-states the charge pump as soon as lock is lost
// [R2] holdover entry senses the lock pin level, whatever lock source drives it
// [R3] lock pin comparator enable bit; when off the pin always reads high
// [R4] charge pump stays tri-stated while no reference edge arrives
// [R5] leaving tri-state on a reference event resets swallow counter, not prescaler
// [R6] no re-entry until lock is back and the lock pin reads high again
// [R7] holdover follows the selected reference; switchover loss ends at next edge
// [R8] lock counter field sets consecutive cycles, 00 means five; window range bit
// [R9] digital lock detect disable bit must stay zero for detection to run
// [R10] lock pin select value 000100 picks current-source lock detect mode
// [R11] external holdover control bit; zero selects automatic holdover
// [R12] holdover enabled only with both enable bits; otherwise all holdover off
// [R13] reference control: auto switchover, preferred reference, two buffer enables
// [R14] three monitors flag references or oscillator below threshold; selectable
// [R15] software sets up loop, reference and no holdover before calibration
// [R16] calibration starts with start bit set then an update strobe
// [R17] calibration never self-starts; only clear, update, set, update restarts
// [R18] calibration finished readback bit reads one after completion
// [R19] output sync held static during calibration, released at its end
// [R20] calibration clock is phase detector rate over the selected divider
// [R21] one calibration takes 4400 calibration clock cycles
// [R22] software should recalibrate after divider or reference changes
// [R23] lock after programmed consecutive good cycles; one bad cycle drops it
// [R24] written bits reach holdover and calibration logic only on update
// [R25] calibration divider field is an opaque two-bit divide selection
package plhv_pkg;
  localparam int          ADDR_W        = 10;
  localparam logic [9:0]  REG_LOCK      = 10'h018;
  localparam logic [9:0]  REG_LDPIN     = 10'h01a;
  localparam logic [9:0]  REG_REF       = 10'h01c;
  localparam logic [9:0]  REG_HOLD      = 10'h01d;
  localparam logic [9:0]  REG_STAT      = 10'h01f;
  localparam logic [9:0]  REG_UPDATE    = 10'h232;
  // field positions
  localparam int          LOCK_CAL_GO   = 0;
  localparam int          LOCK_CALDIV   = 1;
  localparam int          LOCK_DLD_OFF  = 3;
  localparam int          LOCK_WINDOW   = 4;
  localparam int          LOCK_COUNT    = 5;
  localparam int          REF_BUF       = 1;
  localparam int          REF_PREFER    = 3;
  localparam int          REF_AUTO      = 4;
  localparam int          HOLD_EN_A     = 0;
  localparam int          HOLD_EXT      = 1;
  localparam int          HOLD_EN_B     = 2;
  localparam int          HOLD_CMP      = 3;
  localparam int          STAT_THR      = 0;
  localparam int          STAT_BELOW    = 2;
  localparam int          STAT_CALDONE  = 6;
  localparam int          UPDATE_BIT    = 0;
  // reset values
  localparam logic [7:0]  RST_LOCK      = 8'h00;
  localparam logic [5:0]  RST_LDPIN     = 6'h00;
  localparam logic [7:0]  RST_REF       = 8'h00;
  localparam logic [3:0]  RST_HOLD      = 4'h0;
  localparam logic [1:0]  RST_THR       = 2'h0;
  localparam logic [5:0]  LDPIN_CURSRC  = 6'h04;
  // lock counts per 0x018[6:5] code
  localparam logic [7:0]  LOCK_CNT0     = 8'h05;
  localparam logic [7:0]  LOCK_CNT1     = 8'h10;
  localparam logic [7:0]  LOCK_CNT2     = 8'h40;
  localparam logic [7:0]  LOCK_CNT3     = 8'hff;
  // calibration divide values, opaque code
  localparam logic [4:0]  CAL_DIV0      = 5'h02;
  localparam logic [4:0]  CAL_DIV1      = 5'h04;
  localparam logic [4:0]  CAL_DIV2      = 5'h08;
  localparam logic [4:0]  CAL_DIV3      = 5'h10;
  localparam logic [12:0] CAL_CYCLES    = 13'h1130;
  // monitor thresholds: silent time before a source counts as too slow
  localparam int          CLK_NS        = 100;
  localparam int          MON_NORM_NS   = 1000;
  localparam int          MON_EXT_NS    = 100000;
  localparam int          MON_OSC_NS    = 500;
  localparam logic [15:0] MON_NORM_CYC  = 16'(MON_NORM_NS / CLK_NS);
  localparam logic [15:0] MON_EXT_CYC   = 16'(MON_EXT_NS / CLK_NS);
  localparam logic [15:0] MON_OSC_CYC   = 16'(MON_OSC_NS / CLK_NS);
endpackage : plhv_pkg

//--- core/plhv_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface plhv_cfg_if;
  logic       dld_off;
  logic [1:0] count_sel;
  logic       locked;
  logic       cal_go;
  logic [1:0] cal_div_sel;
  logic       cal_busy;
  logic       cal_done;
  modport ctl (output dld_off, count_sel, cal_go, cal_div_sel,
               input  locked, cal_busy, cal_done);
  modport lk  (input  dld_off, count_sel, output locked);
  modport cal (input  cal_go, cal_div_sel, output cal_busy, cal_done);
endinterface : plhv_cfg_if
`default_nettype wire

//--- core/plhv_lock_detect.sv
`timescale 1ns/1ps
`default_nettype none
module plhv_lock_detect
  import plhv_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // phase detector cycle report
  input  wire logic pfd_cycle,
  input  wire logic pfd_in_lock_window,
  input  wire logic pfd_over_unlock,
  // configuration and lock state
  plhv_cfg_if.lk    cfg
);
  import plhv_pkg::*;

  logic [7:0] good_cnt;

  function automatic logic [7:0] lock_target(input logic [1:0] sel);
    unique case (sel)
      2'b00: lock_target = LOCK_CNT0;
      2'b01: lock_target = LOCK_CNT1;
      2'b10: lock_target = LOCK_CNT2;
      2'b11: lock_target = LOCK_CNT3;
    endcase
  endfunction : lock_target

  // run of in-window cycles; the wider unlock threshold drops lock at once
  always_ff @(posedge clock) begin
    if (!rstn || cfg.dld_off) begin  // [R9]
      good_cnt   <= 8'h00;
      cfg.locked <= 1'b0;
    end else if (pfd_cycle) begin
      if (pfd_over_unlock) begin  // [R23]
        good_cnt   <= 8'h00;
        cfg.locked <= 1'b0;
      end else if (pfd_in_lock_window && !cfg.locked) begin
        good_cnt <= good_cnt + 8'h01;
        if (good_cnt + 8'h01 >= lock_target(cfg.count_sel))  // [R8] [R23]
          cfg.locked <= 1'b1;
      end else if (!cfg.locked) begin
        good_cnt <= 8'h00;  // run must be consecutive
      end
    end
  end
endmodule : plhv_lock_detect
`default_nettype wire

//--- core/plhv_cal_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module plhv_cal_ctrl
  import plhv_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // reference path phase detector event
  input  wire logic pfd_ref_event,
  // configuration and calibration state
  plhv_cfg_if.cal   cfg
);
  import plhv_pkg::*;

  typedef enum logic [0:0] {CAL_IDLE = 1'b0, CAL_RUN = 1'b1} plhv_cal_e;

  plhv_cal_e   state;
  logic        go_prev;
  logic [4:0]  div_cnt;
  logic [12:0] cyc_cnt;
  logic        cal_tick;
  logic        start;
  logic        finish;

  function automatic logic [4:0] div_value(input logic [1:0] sel);
    unique case (sel)
      2'b00: div_value = CAL_DIV0;
      2'b01: div_value = CAL_DIV1;
      2'b10: div_value = CAL_DIV2;
      2'b11: div_value = CAL_DIV3;
    endcase
  endfunction : div_value

  // only a rising start bit launches; a bit left high never retriggers
  assign start    = cfg.cal_go && !go_prev && state == CAL_IDLE;  // [R16] [R17]
  assign cal_tick = pfd_ref_event && div_cnt + 5'h01 >= div_value(cfg.cal_div_sel);  // [R20]
  assign finish   = state == CAL_RUN && cal_tick && cyc_cnt == CAL_CYCLES - 13'h0001;  // [R21]
  assign cfg.cal_busy = state == CAL_RUN;  // [R19]

  always_ff @(posedge clock) begin
    if (!rstn) go_prev <= 1'b0;
    else       go_prev <= cfg.cal_go;
  end

  // calibration clock divider on phase detector events
  always_ff @(posedge clock) begin
    if (!rstn || state == CAL_IDLE) div_cnt <= 5'h00;
    else if (cal_tick)              div_cnt <= 5'h00;  // [R25]
    else if (pfd_ref_event)         div_cnt <= div_cnt + 5'h01;
  end

  // sequencer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state   <= CAL_IDLE;
      cyc_cnt <= 13'h0000;
    end else begin
      unique case (state)
        CAL_IDLE: if (start) begin
          state   <= CAL_RUN;
          cyc_cnt <= 13'h0000;
        end
        CAL_RUN: if (finish) state <= CAL_IDLE;
          else if (cal_tick) cyc_cnt <= cyc_cnt + 13'h0001;
      endcase
    end
  end

  // finished flag, cleared when the next calibration begins
  always_ff @(posedge clock) begin
    if (!rstn)       cfg.cal_done <= 1'b0;
    else if (finish) cfg.cal_done <= 1'b1;  // [R18]
    else if (start)  cfg.cal_done <= 1'b0;
  end
endmodule : plhv_cal_ctrl
`default_nettype wire

//--- core/plhv_top.sv
`timescale 1ns/1ps
`default_nettype none
module plhv_top (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rstn,
  // register port
  input  wire logic [plhv_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [7:0]                rdata,
  // phase detector reports
  input  wire logic                      pfd_cycle,
  input  wire logic                      pfd_in_lock_window,
  input  wire logic                      pfd_over_unlock,
  input  wire logic                      pfd_ref_event,
  // lock pin sense
  input  wire logic                      lock_pin_level,
  // edges seen at the monitored sources
  input  wire logic                      first_reference_edge,
  input  wire logic                      second_reference_edge,
  input  wire logic                      osc_edge,
  // loop controls
  output logic                           charge_pump_hiz,
  output logic                           swallow_counter_reset,
  output logic                           output_sync_hold,
  output logic                           digital_lock_detect,
  output logic                           lock_window_high_range,
  // lock pin controls
  output logic      [5:0]                lock_pin_select,
  output logic                           lock_pin_current_source,
  output logic                           lock_pin_comparator_on,
  // reference selection
  output logic                           ref_auto_switch,
  output logic                           ref_prefer_second,
  output logic      [1:0]                ref_buffer_enable,
  // frequency monitors
  output logic      [1:0]                ref_monitor_extended,
  output logic      [2:0]                freq_below
);
  import plhv_pkg::*;

  typedef enum logic [1:0] {
    HO_ARMED = 2'b00,
    HO_HIZ   = 2'b01,
    HO_REARM = 2'b10
  } plhv_hold_e;

  plhv_cfg_if cfg ();

  // shadow registers written by software
  logic [7:0]  sh_lock;
  logic [5:0]  sh_ldpin;
  logic [7:0]  sh_ref;
  logic [3:0]  sh_hold;
  logic [1:0]  sh_thr;
  // active copies the logic uses
  logic [7:0]  act_lock;
  logic [5:0]  act_ldpin;
  logic [7:0]  act_ref;
  logic [3:0]  act_hold;
  logic [1:0]  act_thr;

  logic        update;
  logic        ld_sensed;
  logic        hold_on;
  logic        auto_on;
  plhv_hold_e  hstate;
  plhv_hold_e  next_hstate;
  logic [15:0] mon_cnt [3];
  logic [2:0]  mon_edge;
  logic [15:0] mon_thr [3];
  logic [7:0]  next_rdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    hit = a == r;
  endfunction : hit

  // update strobe: self-clearing, never stored
  assign update = wr && hit(addr, REG_UPDATE) && wdata[UPDATE_BIT];  // [R16] [R24]

  // shadow registers take every write at once
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sh_lock  <= RST_LOCK;
      sh_ldpin <= RST_LDPIN;
      sh_ref   <= RST_REF;
      sh_hold  <= RST_HOLD;
      sh_thr   <= RST_THR;
    end else if (wr) begin
      if (hit(addr, REG_LOCK))  sh_lock  <= wdata;
      if (hit(addr, REG_LDPIN)) sh_ldpin <= wdata[5:0];
      if (hit(addr, REG_REF))   sh_ref   <= wdata & 8'h1e;
      if (hit(addr, REG_HOLD))  sh_hold  <= wdata[3:0];
      if (hit(addr, REG_STAT))  sh_thr   <= wdata[STAT_THR+:2];
    end
  end

  // active copies move only on update, so a half-written setup never acts
  always_ff @(posedge clock) begin
    if (!rstn) begin
      act_lock  <= RST_LOCK;
      act_ldpin <= RST_LDPIN;
      act_ref   <= RST_REF;
      act_hold  <= RST_HOLD;
      act_thr   <= RST_THR;
    end else if (update) begin  // [R24]
      act_lock  <= sh_lock;
      act_ldpin <= sh_ldpin;
      act_ref   <= sh_ref;
      act_hold  <= sh_hold;
      act_thr   <= sh_thr;
    end
  end

  // configuration handed to the lock detector and calibration controller
  assign cfg.dld_off     = act_lock[LOCK_DLD_OFF];  // [R9]
  assign cfg.count_sel   = act_lock[LOCK_COUNT+:2];  // [R8]
  assign cfg.cal_go      = act_lock[LOCK_CAL_GO];  // [R16] [R17]
  assign cfg.cal_div_sel = act_lock[LOCK_CALDIV+:2];  // [R20] [R25]

  plhv_lock_detect u_lock (
    .clock              (clock),
    .rstn               (rstn),
    .pfd_cycle          (pfd_cycle),
    .pfd_in_lock_window (pfd_in_lock_window),
    .pfd_over_unlock    (pfd_over_unlock),
    .cfg                (cfg.lk)
  );

  plhv_cal_ctrl u_cal (
    .clock         (clock),
    .rstn          (rstn),
    .pfd_ref_event (pfd_ref_event),
    .cfg           (cfg.cal)
  );

  // lock pin: the pin carries the chosen lock source back to us as a level;
  // with the comparator off the level is forced high so holdover cannot fire
  assign lock_pin_comparator_on  = act_hold[HOLD_CMP];  // [R3]
  assign ld_sensed               = act_hold[HOLD_CMP] ? lock_pin_level : 1'b1;  // [R2] [R3]
  assign lock_pin_select         = act_ldpin;
  assign lock_pin_current_source = act_ldpin == LDPIN_CURSRC;  // [R10]
  assign digital_lock_detect     = cfg.locked;
  assign lock_window_high_range  = !act_lock[LOCK_WINDOW];  // [R8]

  // holdover enables: both bits needed, external control bit blocks auto mode
  assign hold_on = act_hold[HOLD_EN_A] && act_hold[HOLD_EN_B];  // [R12]
  assign auto_on = hold_on && !act_hold[HOLD_EXT];  // [R11]

  // holdover sequencing
  always_comb begin
    next_hstate = hstate;
    if (!auto_on) begin
      next_hstate = HO_ARMED;  // [R12]
    end else begin
      unique case (hstate)
        HO_ARMED: begin
          if (!ld_sensed) next_hstate = HO_HIZ;  // [R1] [R2]
        end
        HO_HIZ: begin
          // stays here while no reference edge arrives, however long
          if (pfd_ref_event) next_hstate = HO_REARM;  // [R4] [R7]
        end
        HO_REARM: begin
          // a chattering detector would retrigger without this wait
          if (cfg.locked && ld_sensed) next_hstate = HO_ARMED;  // [R6]
        end
        default: next_hstate = HO_ARMED;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) hstate <= HO_ARMED;
    else       hstate <= next_hstate;
  end

  // the exit edge also restarts the swallow counter; prescaler is untouched
  always_ff @(posedge clock) begin
    if (!rstn) swallow_counter_reset <= 1'b0;
    else       swallow_counter_reset <= auto_on && hstate == HO_HIZ && pfd_ref_event;  // [R5]
  end

  assign charge_pump_hiz = hstate == HO_HIZ;  // [R1] [R4]

  // outputs held static for the whole calibration run
  always_ff @(posedge clock) begin
    if (!rstn) output_sync_hold <= 1'b0;
    else       output_sync_hold <= cfg.cal_busy;  // [R19]
  end

  // reference selection controls; the switchover engine lives elsewhere
  assign ref_auto_switch   = act_ref[REF_AUTO];  // [R13]
  assign ref_prefer_second = act_ref[REF_PREFER];  // [R13] [R7]
  assign ref_buffer_enable = act_ref[REF_BUF+:2];  // [R13]

  // frequency monitors: a source is slow when its edges stop for too long
  assign ref_monitor_extended = act_thr;  // [R14]
  assign mon_edge   = {osc_edge, second_reference_edge, first_reference_edge};
  assign mon_thr[0] = act_thr[0] ? MON_EXT_CYC : MON_NORM_CYC;  // [R14]
  assign mon_thr[1] = act_thr[1] ? MON_EXT_CYC : MON_NORM_CYC;
  assign mon_thr[2] = MON_OSC_CYC;

  // counters saturate so a dead source keeps its flag up
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (!rstn || mon_edge[i])        mon_cnt[i] <= 16'h0000;
      else if (mon_cnt[i] != 16'hffff) mon_cnt[i] <= mon_cnt[i] + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (!rstn) freq_below[i] <= 1'b0;
      else       freq_below[i] <= mon_cnt[i] >= mon_thr[i];  // [R14]
    end
  end

  // read mux: shadow values read back, status shows live state
  always_comb begin
    next_rdata = 8'h00;
    if (hit(addr, REG_LOCK))  next_rdata = sh_lock;
    if (hit(addr, REG_LDPIN)) next_rdata = {2'h0, sh_ldpin};
    if (hit(addr, REG_REF))   next_rdata = sh_ref;
    if (hit(addr, REG_HOLD))  next_rdata = {4'h0, sh_hold};
    if (hit(addr, REG_STAT)) begin
      next_rdata[STAT_THR+:2]   = sh_thr;
      next_rdata[STAT_BELOW+:3] = freq_below;  // [R14]
      next_rdata[STAT_CALDONE]  = cfg.cal_done;  // [R18]
    end
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (!rstn)   rdata <= 8'h00;
    else if (rd) rdata <= next_rdata;
    else         rdata <= 8'h00;
  end
endmodule : plhv_top
`default_nettype wire

//--- testbench/plhv_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module plhv_top_asserts (
  // clock, reset, bus
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // loop reports
  input wire logic       pfd_cycle,
  input wire logic       pfd_in_lock_window,
  input wire logic       pfd_over_unlock,
  input wire logic       pfd_ref_event,
  input wire logic       lock_pin_level,
  // controls
  input wire logic       charge_pump_hiz,
  input wire logic       swallow_counter_reset,
  input wire logic       output_sync_hold,
  input wire logic       digital_lock_detect,
  input wire logic [5:0] lock_pin_select,
  input wire logic       lock_pin_current_source,
  input wire logic       lock_pin_comparator_on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [7:0]  good_run;
  logic [15:0] sync_ev;
  // good compares in a row, saturating
  always_ff @(posedge clock) begin
    if (!rstn || (pfd_cycle && !pfd_in_lock_window)) begin
      good_run <= 8'h00;
    end else if (pfd_cycle && good_run != 8'hff) begin
      good_run <= good_run + 8'h01;
    end
  end
  // ref events while held
  always_ff @(posedge clock) begin
    if (!rstn || !output_sync_hold) begin
      sync_ev <= 16'h0000;
    end else if (pfd_ref_event) begin
      sync_ev <= sync_ev + 16'h0001;
    end
  end
  chk_hiz_entry: assert property ($rose(charge_pump_hiz) |->
    $past(lock_pin_comparator_on) && !$past(lock_pin_level))
    else $error("hiz entry");
  chk_hiz_hold: assert property (
    (charge_pump_hiz && !pfd_ref_event && !wr && !$past(wr)) |=> charge_pump_hiz)
    else $error("hiz left");
  chk_hiz_exit: assert property (
    (charge_pump_hiz && pfd_ref_event) |=> !charge_pump_hiz && swallow_counter_reset)
    else $error("hiz exit");
  chk_swallow_cause: assert property (swallow_counter_reset |->
    $past(charge_pump_hiz) && $past(pfd_ref_event))
    else $error("swallow cause");
  chk_lock_rise: assert property ($rose(digital_lock_detect) |-> good_run >= 8'h05)
    else $error("lock early");
  chk_lock_drop: assert property (
    (digital_lock_detect && pfd_cycle && pfd_over_unlock) |=> !digital_lock_detect)
    else $error("lock kept");
  chk_cursrc_mode: assert property (
    lock_pin_current_source == (lock_pin_select == 6'h04))
    else $error("current source");
  chk_sync_span: assert property ($fell(output_sync_hold) |-> sync_ev >= 16'h225b)
    else $error("sync early");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata idle");
endmodule : plhv_top_asserts
bind plhv_top plhv_top_asserts u_plhv_top_asserts (.*);
`default_nettype wire

//--- testbench/plhv_pll_model.sv
`timescale 1ns/1ps
`default_nettype none
module plhv_pll_model (
  // clock, reset and scenario controls
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic ref_on,
  input  wire logic slow,
  input  wire logic phase_ok,
  input  wire logic second_reference_on,
  input  wire logic osc_on,
  input  wire logic digital_lock_detect,
  // loop reports
  output logic      pfd_cycle,
  output logic      pfd_in_lock_window,
  output logic      pfd_over_unlock,
  output logic      pfd_ref_event,
  output logic      lock_pin_level,
  output logic      first_reference_edge,
  output logic      second_reference_edge,
  output logic      osc_edge
);
  logic       pace;
  logic [3:0] charge;
  // slow pace halves the reference rate
  always_ff @(posedge clock) pace <= rstn && !pace;
  // pin capacitor: charges while locked, empties at once
  always_ff @(posedge clock) begin
    if (!rstn || !digital_lock_detect) begin
      charge <= 4'h0;
    end else if (charge != 4'hf) begin
      charge <= charge + 4'h1;
    end
  end
  assign lock_pin_level     = (charge == 4'hf);
  assign pfd_ref_event      = ref_on && (!slow || pace);
  assign pfd_cycle          = pfd_ref_event;
  // qualifiers carry noise outside compare cycles
  assign pfd_in_lock_window = pfd_cycle ? phase_ok : pace;
  assign pfd_over_unlock    = pfd_cycle ? !phase_ok : !pace;
  assign first_reference_edge          = ref_on;
  assign second_reference_edge          = second_reference_on;
  assign osc_edge           = osc_on;
endmodule : plhv_pll_model
`default_nettype wire

//--- testbench/plhv_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module plhv_top_tb;
  import plhv_pkg::*;
  logic clock, rstn, wr, rd, ref_on, slow, phase_ok, second_reference_on, osc_on;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, v;
  logic pfd_cycle, pfd_in_lock_window, pfd_over_unlock, pfd_ref_event, lock_pin_level;
  logic first_reference_edge, second_reference_edge, osc_edge, charge_pump_hiz, swallow_counter_reset;
  logic output_sync_hold, digital_lock_detect, lock_window_high_range;
  logic lock_pin_current_source, lock_pin_comparator_on, ref_auto_switch, ref_prefer_second;
  logic [5:0] lock_pin_select;
  logic [1:0] ref_buffer_enable, ref_monitor_extended;
  logic [2:0] freq_below;
  logic [31:0] seed = 32'h5e838957;
  logic [7:0] modes [3] = '{8'h05, 8'h0f, 8'h09};
  int lcnt [4] = '{5, 16, 64, 255};
  int failures = 0, check_count = 0, n;
  plhv_top u_plhv_top (.*);
  plhv_pll_model u_plhv_pll_model (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // implemented bits only
  function automatic logic [7:0] rb_mask(input logic [9:0] a, input logic [7:0] d);
    return (a == REG_REF) ? (d & 8'h1e) : (d & 8'h3f);
  endfunction : rb_mask
  // cal length in reference events
  function automatic int cal_len(input int code);
    return 4400 * (2 << code);
  endfunction : cal_len
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [9:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rreg
  // update, then settle
  task automatic upd();
    wreg(REG_UPDATE, 8'h01);
    @(negedge clock);
  endtask : upd
  // one bad compare, then no reference
  task automatic lose_ref();
    @(posedge clock);
    phase_ok <= 1'b0;
    @(posedge clock);
    ref_on <= 1'b0;
    phase_ok <= 1'b1;
  endtask : lose_ref
  task automatic wait_cal(input int code);
    for (n = 0; n < 6 && output_sync_hold !== 1'b1; n++) @(negedge clock);
    for (n = 0; n < 40000 && output_sync_hold !== 1'b0; n++) @(negedge clock);
    chk("cal length", 8'h01, 8'(n > cal_len(code) - 9 && n < cal_len(code) + 9));
  endtask : wait_cal
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial begin
    clock = 1'b0;
    forever #50 clock = !clock;
  end
  // watchdog: two calibrations plus margin
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    report_and_stop();
  end
  initial begin
    {rstn, wr, rd, ref_on, slow, addr, wdata} = '0;
    {phase_ok, second_reference_on, osc_on} = 3'b111;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk("reset outputs", 8'h10, {lock_window_high_range, lock_pin_comparator_on,
      charge_pump_hiz, output_sync_hold, digital_lock_detect});
    wreg(10'h3ff, 8'hff);
    rreg(10'h3ff, v);
    chk("unmapped read", 8'h00, v);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wreg(REG_REF, seed[7:0]);
      rreg(REG_REF, v);
      chk("ref readback", rb_mask(REG_REF, seed[7:0]), v);
      wreg(REG_LDPIN, seed[15:8]);
      rreg(REG_LDPIN, v);
      chk("pin readback", rb_mask(REG_LDPIN, seed[15:8]), v);
    end
    chk("shadow only", 8'h00, {ref_buffer_enable, lock_pin_select});
    wreg(REG_LOCK, 8'h00);
    wreg(REG_LDPIN, {2'b00, LDPIN_CURSRC});
    wreg(REG_REF, 8'h16);
    wreg(REG_HOLD, 8'h0d);
    ref_on <= 1'b1;
    upd();
    chk("ref controls", 8'h0b, {ref_auto_switch, ref_prefer_second, ref_buffer_enable});
    chk("pin controls", 8'h07, {lock_pin_current_source, lock_pin_comparator_on,
      lock_window_high_range});
    for (n = 0; n < 60 && lock_pin_level !== 1'b1; n++) @(negedge clock);
    chk("locked", 8'h01, digital_lock_detect);
    $display("test setup finished");
    lose_ref();
    for (n = 0; n < 20 && charge_pump_hiz !== 1'b1; n++) @(negedge clock);
    chk("hiz on loss", 8'h01, charge_pump_hiz);
    repeat (30) @(negedge clock);
    chk("hiz held", 8'h01, charge_pump_hiz);
    @(posedge clock);
    slow <= 1'b1;
    ref_on <= 1'b1;
    for (n = 0; n < 10 && charge_pump_hiz !== 1'b0; n++) @(negedge clock);
    chk("hiz released", 8'h00, charge_pump_hiz);
    repeat (3) @(negedge clock);
    chk("no reentry", 8'h00, charge_pump_hiz);
    for (n = 0; n < 90 && lock_pin_level !== 1'b1; n++) @(negedge clock);
    slow <= 1'b0;
    lose_ref();
    for (n = 0; n < 20 && charge_pump_hiz !== 1'b1; n++) @(negedge clock);
    chk("rearmed", 8'h01, charge_pump_hiz);
    foreach (modes[i]) begin
      ref_on <= 1'b1;
      for (n = 0; n < 90 && lock_pin_level !== 1'b1; n++) @(negedge clock);
      wreg(REG_HOLD, modes[i]);
      upd();
      lose_ref();
      repeat (20) @(negedge clock);
      chk("hiz refused", 8'h00, charge_pump_hiz);
    end
    ref_on <= 1'b1;
    $display("test holdover finished");
    foreach (lcnt[c]) begin
      wreg(REG_LOCK, 8'(c << 5));
      upd();
      @(posedge clock);
      phase_ok <= 1'b0;
      @(posedge clock);
      phase_ok <= 1'b1;
      @(negedge clock);
      for (n = 0; n < 300 && digital_lock_detect !== 1'b1; n++) @(negedge clock);
      chk("lock count", 8'h01, 8'(n >= lcnt[c] - 2 && n <= lcnt[c] + 1));
    end
    wreg(REG_LOCK, 8'h18);
    upd();
    repeat (20) @(negedge clock);
    chk("lock off", 8'h00, {digital_lock_detect, lock_window_high_range});
    $display("test lock finished");
    wreg(REG_HOLD, 8'h00);
    wreg(REG_LOCK, 8'h01);
    upd();
    wait_cal(0);
    rreg(REG_STAT, v);
    chk("cal done", 8'h01, v[6]);
    upd();
    repeat (10) @(negedge clock);
    chk("no restart", 8'h00, output_sync_hold);
    wreg(REG_LOCK, 8'h02);
    upd();
    wreg(REG_LOCK, 8'h03);
    upd();
    wait_cal(1);
    $display("test calibration finished");
    @(posedge clock);
    second_reference_on <= 1'b0;
    osc_on <= 1'b0;
    repeat (15) @(negedge clock);
    rreg(REG_STAT, v);
    chk("monitor flags", 8'h58, v);
    wreg(REG_STAT, 8'h02);
    upd();
    chk("extended select", 8'h02, ref_monitor_extended);
    @(posedge clock);
    second_reference_on <= 1'b1;
    osc_on <= 1'b1;
    repeat (3) @(posedge clock);
    second_reference_on <= 1'b0;
    repeat (20) @(negedge clock);
    chk("extended threshold", 8'h00, freq_below[1]);
    $display("test monitors finished");
    report_and_stop();
  end
endmodule : plhv_top_tb
`default_nettype wire
